/* include/dmd_pkg.sv */
package dmd_pkg;

    // register byte offsets on the avalon slave
    localparam logic [4:0] DMD_OFS_CTRL   = 5'h00;
    localparam logic [4:0] DMD_OFS_STATUS = 5'h04;
    localparam logic [4:0] DMD_OFS_MASK   = 5'h08;
    localparam logic [4:0] DMD_OFS_PINS   = 5'h0c;

    // serial frame layout, msb first
    localparam int DMD_FRAME_BITS  = 16;
    localparam int DMD_PEC_BITS    = 24;
    localparam int DMD_ADDR_HI     = 15;
    localparam int DMD_ADDR_LO     = 13;
    localparam int DMD_RDBK_BIT    = 12;

    // control word fields (low 12 bits of a frame)
    localparam int DMD_CTL_W       = 12;
    localparam int DMD_RANGE_HI    = 3;
    localparam int DMD_RANGE_LO    = 0;
    localparam int DMD_OE_BIT      = 4;
    localparam int DMD_CLR_BIT     = 5;
    localparam int DMD_CSEL_BIT    = 6;
    localparam int DMD_CHK_BIT     = 7;
    localparam int DMD_SENSE_BIT   = 8;
    localparam logic [11:0] DMD_CTL_RST = 12'h000;

    // status bits, sticky, cleared by a read
    localparam int DMD_ST_W        = 5;
    localparam int DMD_ST_LATCH    = 0;
    localparam int DMD_ST_CHKERR   = 1;
    localparam int DMD_ST_HOT      = 2;
    localparam int DMD_ST_OPEN     = 3;
    localparam int DMD_ST_BADLEN   = 4;
    localparam logic [4:0] DMD_MASK_RST = 5'h00;

    // crc-8 polynomial x^8 + x^2 + x + 1
    localparam logic [7:0] DMD_CRC_POLY = 8'h07;
    localparam logic [7:0] DMD_CRC_INIT = 8'h00;

    // number of synchronised pins
    localparam int DMD_NPINS = 12;

    // pins as seen from outside, one bundle
    typedef struct packed {
        logic shift_clk;       // serial clock or output_enable_pin
        logic frame_latch;     // latch strobe or sense_resistor_select
        logic serial_in;       // serial_in or range_decode_bit0
        logic addr2;           // device_addr_bit2 or range_decode_bit1
        logic addr1;           // device_addr_bit1 or range_decode_bit2
        logic addr0;           // device_addr_bit0 or range_decode_bit3
        logic clear_pin;       // active high clear
        logic clear_value_select;
        logic dev_reset_n;     // soft reset, software mode only
        logic mode_strap;      // 0 software, 1 hardware
        logic over_temp;       // from thermal sensor
        logic open_circuit;    // from output loop monitor
    } dmd_pins_t;

    // controls handed to the analog stage
    typedef struct packed {
        logic [3:0] range;
        logic       enable;
        logic       sense_internal;
        logic       clear;
        logic       clear_mid;
    } dmd_drive_t;

    // crc over a 16 bit word, msb first
    function automatic logic [7:0] dmd_crc16(input logic [15:0] d);
        logic [7:0] c;
        c = DMD_CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            if (c[7] ^ d[i]) begin
                c = {c[6:0], 1'b0} ^ DMD_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : dmd_crc16

endpackage : dmd_pkg

/* core/dmd_sync.sv */
// two flop synchroniser, one chain per bit
module dmd_sync
    import dmd_pkg::*;
#(
    parameter int W = DMD_NPINS
) (
    input  wire logic         CLK,
    input  wire logic         NRST,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    // first stage only feeds the second
    logic [W-1:0] meta_r;

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // plain double flop, reset to zero
            always_ff @(posedge CLK or negedge NRST) begin
                if (!NRST) begin
                    meta_r[g]   <= 1'b0;
                    sync_out[g] <= 1'b0;
                end else begin
                    meta_r[g]   <= async_in[g];
                    sync_out[g] <= meta_r[g];
                end
            end
        end
    endgenerate

endmodule : dmd_sync

/* core/dmd_front.sv */
// Notes on behaviour
// - shift serial_in on falling shift clock
// - readback bit launched rising, sampled falling
// - latch rising edge loads control, updates output
// - clear value select, software ORs bit
// - clear pin ORed with bit forces value
// - hardware: sense select low external, high internal
// - hardware: shift clock pin is output enable
// - hardware: four range pins pick range
// - software: three address pins pick device
// - strap low software, high hardware
// - software: reset pin low restores power-on
// - software: fault low on open, hot, check
// - hardware: fault pin reports overtemperature only
// - hardware: open circuit pin, unused in software
// - software range from control register bits
//
// Added by the designer: the register addresses and register access over Avalon-MM.
module dmd_front
    import dmd_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        NRST,
    // avalon-mm slave
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             IRQ,
    // shared pins, asynchronous to CLK
    input  wire logic        SHIFT_CLK_PIN,
    input  wire logic        FRAME_LATCH_PIN,
    input  wire logic        SERIAL_IN_PIN,
    input  wire logic        ADDR2_PIN,
    input  wire logic        ADDR1_PIN,
    input  wire logic        ADDR0_PIN,
    input  wire logic        CLEAR_PIN,
    input  wire logic        CLEAR_VALUE_SELECT_PIN,
    input  wire logic        DEV_RESET_N_PIN,
    input  wire logic        MODE_STRAP_PIN,
    // analog monitors
    input  wire logic        OVER_TEMP,
    input  wire logic        OPEN_CIRCUIT,
    // pin outputs
    output logic             SERIAL_OUT,
    output logic             FAULT_PULL_OE,
    output logic             OPEN_ALERT_PULL_OE,
    // to analog stage
    output dmd_drive_t       DRIVE
);

    // synchronised pin bundle
    dmd_pins_t pins_raw;
    dmd_pins_t pins;
    logic [DMD_NPINS-1:0] pins_vec;

    assign pins_raw = '{
        shift_clk:          SHIFT_CLK_PIN,
        frame_latch:        FRAME_LATCH_PIN,
        serial_in:          SERIAL_IN_PIN,
        addr2:              ADDR2_PIN,
        addr1:              ADDR1_PIN,
        addr0:              ADDR0_PIN,
        clear_pin:          CLEAR_PIN,
        clear_value_select: CLEAR_VALUE_SELECT_PIN,
        dev_reset_n:        DEV_RESET_N_PIN,
        mode_strap:         MODE_STRAP_PIN,
        over_temp:          OVER_TEMP,
        open_circuit:       OPEN_CIRCUIT
    };

    dmd_sync #(
        .W(DMD_NPINS)
    ) u_sync (
        .CLK      (CLK),
        .NRST     (NRST),
        .async_in (pins_raw),
        .sync_out (pins_vec)
    );

    assign pins = dmd_pins_t'(pins_vec);

    // state
    logic                 mode_hw_r;     // latched strap
    logic                 mode_taken_r;  // strap caught once
    logic [1:0]           strap_wait_r;  // edges until sync holds strap
    logic                 sclk_d_r;      // last synced shift clock
    logic                 latch_d_r;     // last synced latch strobe
    logic                 hot_d_r;       // last over temp
    logic                 open_d_r;      // last open circuit
    logic [23:0]          shift_r;       // input shift register
    logic [4:0]           count_r;       // falls in this frame
    logic [DMD_CTL_W-1:0] ctl_r;         // serial control word
    logic [15:0]          rdbk_r;        // readback shifter
    logic                 chk_err_r;     // last frame failed check
    logic [DMD_ST_W-1:0]  status_r;
    logic [DMD_ST_W-1:0]  mask_r;
    logic                 ack_r;         // internal bus answer
    logic [31:0]          rdata_r;

    // next values
    logic [23:0]          shift_nxt;
    logic [4:0]           count_nxt;
    logic [DMD_CTL_W-1:0] ctl_nxt;
    logic [15:0]          rdbk_nxt;
    logic                 chk_err_nxt;
    logic [DMD_ST_W-1:0]  status_nxt;

    // mode decode
    wire sw_mode = ~mode_hw_r;

    // edges on the synchronised link pins
    wire sclk_fall  = sclk_d_r & ~pins.shift_clk;
    wire sclk_rise  = ~sclk_d_r & pins.shift_clk;
    wire latch_rise = ~latch_d_r & pins.frame_latch;

    // software-mode soft reset, ignored in hardware mode
    // soft reset gate
    wire soft_rst = sw_mode & ~pins.dev_reset_n;

    // pins idle high: edges ignored until the strap is caught
    wire sw_live  = sw_mode & mode_taken_r & ~soft_rst;
    wire do_shift = sw_live & sclk_fall;
    wire do_latch = sw_live & latch_rise;
    wire do_out   = sw_live & sclk_rise;

    // frame fields at the latch edge
    wire        chk_on    = ctl_r[DMD_CHK_BIT];
    wire        len_plain = (count_r == 5'(DMD_FRAME_BITS));
    wire        len_chk   = (count_r == 5'(DMD_PEC_BITS));
    wire [15:0] word_chk  = shift_r[23:8];
    wire [15:0] word      = chk_on ? word_chk : shift_r[15:0];
    wire [7:0]  crc_got   = shift_r[7:0];
    wire [7:0]  crc_want  = dmd_crc16(word_chk);
    wire        len_ok    = chk_on ? len_chk : len_plain;
    wire        crc_bad   = chk_on & len_chk & (crc_got != crc_want);
    wire [2:0]  my_addr   = {pins.addr2, pins.addr1, pins.addr0};
    wire        addr_ok   = (word[DMD_ADDR_HI:DMD_ADDR_LO] == my_addr);
    wire        accept    = do_latch & len_ok & ~crc_bad & addr_ok;
    wire        want_rdbk = word[DMD_RDBK_BIT];

    // readback word: status view plus control
    wire [15:0] rdbk_word = {pins.over_temp, pins.open_circuit,
                             chk_err_r, 1'b0, ctl_r};

    // serial datapath next state
    always_comb begin
        shift_nxt   = shift_r;
        count_nxt   = count_r;
        ctl_nxt     = ctl_r;
        rdbk_nxt    = rdbk_r;
        chk_err_nxt = chk_err_r;
        if (soft_rst) begin
            // back to power-on values
            shift_nxt   = '0;
            count_nxt   = '0;
            ctl_nxt     = DMD_CTL_RST;
            rdbk_nxt    = '0;
            chk_err_nxt = 1'b0;
        end else if (do_latch) begin
            count_nxt = '0;
            if (accept) begin
                ctl_nxt     = word[DMD_CTL_W-1:0];
                chk_err_nxt = 1'b0;
                if (want_rdbk) begin
                    rdbk_nxt = rdbk_word;
                end
            end else if (crc_bad) begin
                chk_err_nxt = 1'b1;
            end
        end else begin
            if (do_shift) begin
                shift_nxt = {shift_r[22:0], pins.serial_in};
                if (count_r != 5'h1f) begin
                    count_nxt = count_r + 5'h01;
                end
            end
            if (do_out) begin
                rdbk_nxt = {rdbk_r[14:0], 1'b0};
            end
        end
    end

    // strap catch and edge history
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode_hw_r    <= 1'b0;
            mode_taken_r <= 1'b0;
            strap_wait_r <= 2'h0;
            sclk_d_r     <= 1'b0;
            latch_d_r    <= 1'b0;
            hot_d_r      <= 1'b0;
            open_d_r     <= 1'b0;
        end else begin
            // strap caught once the sync chain holds it
            if (!mode_taken_r) begin
                if (strap_wait_r == 2'h2) begin
                    mode_hw_r    <= pins.mode_strap;
                    mode_taken_r <= 1'b1;
                end else begin
                    strap_wait_r <= strap_wait_r + 2'h1;
                end
            end
            sclk_d_r  <= pins.shift_clk;
            latch_d_r <= pins.frame_latch;
            hot_d_r   <= pins.over_temp;
            open_d_r  <= pins.open_circuit;
        end
    end

    // serial registers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            shift_r   <= '0;
            count_r   <= '0;
            ctl_r     <= DMD_CTL_RST;
            rdbk_r    <= '0;
            chk_err_r <= 1'b0;
        end else begin
            shift_r   <= shift_nxt;
            count_r   <= count_nxt;
            ctl_r     <= ctl_nxt;
            rdbk_r    <= rdbk_nxt;
            chk_err_r <= chk_err_nxt;
        end
    end

    // drive selection per mode
    // software range from control
    wire [3:0] hw_range = {pins.addr0, pins.addr1, pins.addr2,
                           pins.serial_in};
    wire [3:0] range_sel = sw_mode
                         ? ctl_r[DMD_RANGE_HI:DMD_RANGE_LO] : hw_range;
    // hardware enable from shift clock pin
    wire en_sel    = sw_mode ? ctl_r[DMD_OE_BIT] : pins.shift_clk;
    wire sense_sel = sw_mode ? ctl_r[DMD_SENSE_BIT] : pins.frame_latch;
    wire clr_sel   = pins.clear_pin | (sw_mode & ctl_r[DMD_CLR_BIT]);
    // clear value select ORed in software
    wire mid_sel   = pins.clear_value_select
                   | (sw_mode & ctl_r[DMD_CSEL_BIT]);

    wire fault_sw  = pins.open_circuit | pins.over_temp | chk_err_r;
    wire fault_sel = sw_mode ? fault_sw : pins.over_temp;
    // open alert only in hardware mode
    wire open_sel  = ~sw_mode & pins.open_circuit;

    // output flops toward pins and analog stage
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            DRIVE              <= '0;
            SERIAL_OUT         <= 1'b0;
            FAULT_PULL_OE      <= 1'b0;
            OPEN_ALERT_PULL_OE <= 1'b0;
        end else begin
            DRIVE              <= '{range: range_sel, enable: en_sel,
                                    sense_internal: sense_sel,
                                    clear: clr_sel, clear_mid: mid_sel};
            SERIAL_OUT         <= sw_mode & rdbk_nxt[15];
            FAULT_PULL_OE      <= fault_sel;
            OPEN_ALERT_PULL_OE <= open_sel;
        end
    end

    // event sources for the sticky status
    wire [DMD_ST_W-1:0] ev;
    assign ev[DMD_ST_LATCH]  = accept;
    assign ev[DMD_ST_CHKERR] = do_latch & crc_bad;
    assign ev[DMD_ST_HOT]    = pins.over_temp & ~hot_d_r;
    assign ev[DMD_ST_OPEN]   = pins.open_circuit & ~open_d_r;
    assign ev[DMD_ST_BADLEN] = do_latch & ~len_ok;

    // bus decode, one wait cycle before every answer
    wire bus_req  = AVS_READ | AVS_WRITE;
    wire bus_take = bus_req & ack_r;
    wire hit_ctrl = (AVS_ADDRESS == DMD_OFS_CTRL);
    wire hit_stat = (AVS_ADDRESS == DMD_OFS_STATUS);
    wire hit_mask = (AVS_ADDRESS == DMD_OFS_MASK);
    wire hit_pins = (AVS_ADDRESS == DMD_OFS_PINS);
    wire rd_stat  = bus_take & AVS_READ & hit_stat;
    wire wr_mask  = bus_take & AVS_WRITE & hit_mask & AVS_BYTEENABLE[0];

    // read mux, unmapped reads give zero
    wire [31:0] rd_mux =
        hit_ctrl ? {20'h00000, ctl_r} :
        hit_stat ? {27'h0000000, status_r} :
        hit_mask ? {27'h0000000, mask_r} :
        hit_pins ? {16'h0000, 7'h00, mode_hw_r,
                    DRIVE.range, DRIVE.enable, DRIVE.sense_internal,
                    DRIVE.clear, DRIVE.clear_mid} :
        32'h00000000;

    // set wins over the read clear
    always_comb begin
        status_nxt = status_r;
        if (rd_stat) begin
            // clear only what the read returned
            status_nxt = status_r & ~AVS_READDATA[DMD_ST_W-1:0];
        end
        status_nxt = status_nxt | ev;
    end

    // bus answer and interrupt flops
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ack_r    <= 1'b0;
            rdata_r  <= '0;
            status_r <= '0;
            mask_r   <= DMD_MASK_RST;
            IRQ      <= 1'b0;
        end else begin
            // answer pulses one cycle after request seen
            ack_r    <= bus_req & ~ack_r;
            rdata_r  <= rd_mux;
            status_r <= status_nxt;
            if (wr_mask) begin
                mask_r <= AVS_WRITEDATA[DMD_ST_W-1:0];
            end
            IRQ <= |(status_nxt & (wr_mask
                   ? AVS_WRITEDATA[DMD_ST_W-1:0] : mask_r));
        end
    end

    // waitrequest low exactly while ack is up
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= '0;
        end else begin
            AVS_WAITREQUEST <= ~(bus_req & ~ack_r & ~bus_take);
            AVS_READDATA    <= rd_mux;
        end
    end

endmodule : dmd_front

/* tb/dmd_front_checker.sv */
module dmd_front_checker
    import dmd_pkg::*;
(
    input wire logic       CLK,
    input wire logic       NRST,
    input wire logic       AVS_READ,
    input wire logic       AVS_WRITE,
    input wire logic       AVS_WAITREQUEST,
    input wire logic       SHIFT_CLK_PIN,
    input wire logic       FRAME_LATCH_PIN,
    input wire logic       SERIAL_IN_PIN,
    input wire logic       ADDR2_PIN,
    input wire logic       ADDR1_PIN,
    input wire logic       ADDR0_PIN,
    input wire logic       CLEAR_PIN,
    input wire logic       CLEAR_VALUE_SELECT_PIN,
    input wire logic       MODE_STRAP_PIN,
    input wire logic       OVER_TEMP,
    input wire logic       OPEN_CIRCUIT,
    input wire logic       SERIAL_OUT,
    input wire logic       FAULT_PULL_OE,
    input wire logic       OPEN_ALERT_PULL_OE,
    input wire dmd_drive_t DRIVE
);
    // hardware pins in the order of the drive bundle
    wire logic [7:0] hw_in = {ADDR0_PIN, ADDR1_PIN, ADDR2_PIN,
        SERIAL_IN_PIN, SHIFT_CLK_PIN, FRAME_LATCH_PIN, CLEAR_PIN,
        CLEAR_VALUE_SELECT_PIN};
    // one domain, all checks sleep in reset
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    // six stable samples cover sync flops plus output flop
    a_wait_answer: assert property (
        (AVS_READ || AVS_WRITE) && !$past(AVS_READ || AVS_WRITE)
        |-> AVS_WAITREQUEST ##[1:2] !AVS_WAITREQUEST)
        else $error("bus access not answered in time");
    a_wait_pulse: assert property (
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low longer than one cycle");
    a_hw_pins_drive: assert property (
        (MODE_STRAP_PIN && $stable(hw_in)) [*6] |-> DRIVE == hw_in)
        else $error("hardware pins not reflected on drive");
    a_clear_force: assert property (
        CLEAR_PIN [*6] |-> DRIVE.clear)
        else $error("clear pin did not force clear");
    a_clear_mid: assert property (
        CLEAR_VALUE_SELECT_PIN [*6] |-> DRIVE.clear_mid)
        else $error("clear value select ignored");
    a_sw_fault: assert property (
        (!MODE_STRAP_PIN && (OVER_TEMP || OPEN_CIRCUIT)) [*6]
        |-> FAULT_PULL_OE)
        else $error("software fault not pulled");
    a_hw_temp: assert property (
        (MODE_STRAP_PIN && $stable(OVER_TEMP)) [*6]
        |-> FAULT_PULL_OE == OVER_TEMP)
        else $error("hardware fault pin not over temp only");
    a_hw_open: assert property (
        (MODE_STRAP_PIN && $stable(OPEN_CIRCUIT)) [*6]
        |-> OPEN_ALERT_PULL_OE == OPEN_CIRCUIT)
        else $error("open alert does not follow monitor");
    a_sw_open_quiet: assert property (
        !MODE_STRAP_PIN |-> !OPEN_ALERT_PULL_OE)
        else $error("open alert active in software mode");
    a_hw_out_quiet: assert property (
        MODE_STRAP_PIN |-> !SERIAL_OUT)
        else $error("readback active in hardware mode");
endmodule : dmd_front_checker

bind dmd_front dmd_front_checker u_chk (
    .CLK, .NRST, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST,
    .SHIFT_CLK_PIN, .FRAME_LATCH_PIN, .SERIAL_IN_PIN, .ADDR2_PIN,
    .ADDR1_PIN, .ADDR0_PIN, .CLEAR_PIN, .CLEAR_VALUE_SELECT_PIN,
    .MODE_STRAP_PIN, .OVER_TEMP, .OPEN_CIRCUIT, .SERIAL_OUT,
    .FAULT_PULL_OE, .OPEN_ALERT_PULL_OE, .DRIVE
);

/* tb/dmd_host_model.sv */
module dmd_host_model (
    output logic      sck,   // shift clock, idles high
    output logic      latch, // frame strobe, idles high
    output logic      sdata, // data toward the device
    input  wire logic sback  // readback from the device
);
    timeunit 1ns;
    timeprecision 1ps;
    // link clock stands still between frames
    initial begin
        sck = 1'b1;
        latch = 1'b1;
        sdata = 1'b0;
    end
    // one frame msb first, 160 ns per bit, long high phase
    task automatic frame(input logic [23:0] w, input int n,
                         output logic [23:0] rb);
        rb = 24'h0;
        latch = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            // data set well before the fall
            sdata = w[i];
            #60;
            sck = 1'b0;
            rb = {rb[22:0], sback};
            #40;
            sck = 1'b1;
            #60;
        end
        // strobe rises only after the last fall
        latch = 1'b1;
        // released line shows the inverse, not a stale copy
        sdata = ~sdata;
        #400;
    endtask : frame
    // static straps for hardware mode, off the clock edge
    task automatic hw_pins(input logic oe, sense, r0);
        #3;
        sck = oe;
        latch = sense;
        sdata = r0;
    endtask : hw_pins
endmodule : dmd_host_model

/* tb/dmd_front_tb.sv */
module dmd_front_tb
    import dmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [31:0] d; logic [31:0] m;} dmd_note_t;
    logic CLK = 0, NRST = 0, AVS_READ = 0, AVS_WRITE = 0;
    logic [4:0]  AVS_ADDRESS = 5'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
    logic [3:0]  AVS_BYTEENABLE = 4'hf; // whole words only
    logic AVS_WAITREQUEST, IRQ, SHIFT_CLK_PIN, FRAME_LATCH_PIN;
    logic SERIAL_IN_PIN, ADDR2_PIN = 1, ADDR1_PIN = 1, ADDR0_PIN = 0;
    logic CLEAR_PIN = 0, CLEAR_VALUE_SELECT_PIN = 0, DEV_RESET_N_PIN = 1;
    logic MODE_STRAP_PIN = 0, OVER_TEMP = 0, OPEN_CIRCUIT = 0;
    logic SERIAL_OUT, FAULT_PULL_OE, OPEN_ALERT_PULL_OE;
    dmd_drive_t  DRIVE;
    dmd_note_t   notes[$], nt;   // expected read data, oldest first
    int          fail_count = 0, checks_done = 0;
    logic [15:0] seed = 16'h0006; // random source
    logic [11:0] last;            // last accepted control word
    logic [23:0] rbw;             // readback caught by the host
    logic [2:0]  ad;              // our own device address
    always #10 CLK = ~CLK;
    dmd_front u_dut (.CLK, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
        .IRQ, .SHIFT_CLK_PIN, .FRAME_LATCH_PIN, .SERIAL_IN_PIN, .ADDR2_PIN,
        .ADDR1_PIN, .ADDR0_PIN, .CLEAR_PIN, .CLEAR_VALUE_SELECT_PIN,
        .DEV_RESET_N_PIN, .MODE_STRAP_PIN, .OVER_TEMP, .OPEN_CIRCUIT,
        .SERIAL_OUT, .FAULT_PULL_OE, .OPEN_ALERT_PULL_OE, .DRIVE);
    dmd_host_model u_host (.sck(SHIFT_CLK_PIN), .latch(FRAME_LATCH_PIN),
        .sdata(SERIAL_IN_PIN), .sback(SERIAL_OUT));
    // maximal 16 bit lfsr
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand
    // own crc, msb first
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = DMD_CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? DMD_CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8
    // drive expected in software mode, pins ored in
    function automatic dmd_drive_t dexp(input logic [11:0] c);
        return '{c[3:0], c[4], c[8], c[5] | CLEAR_PIN,
                 c[6] | CLEAR_VALUE_SELECT_PIN};
    endfunction : dexp
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do begin
            @(posedge CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
        if (n >= 40) begin
            fail_count++;
            close_out();
        end else begin
            AVS_WRITE <= 1'b0;
            AVS_READ <= 1'b0;
        end
    endtask : bus
    task automatic rd(input logic [4:0] a, input logic [31:0] e, m);
        notes.push_back('{e, m});
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic settle();
        repeat (12) @(posedge CLK);
    endtask : settle
    // frame toward the device, optional crc and crc damage
    task automatic send(input logic [2:0] a, input logic r,
        input logic [11:0] c, input int n, input logic [7:0] bad);
        logic [15:0] f;
        f = {a, r, c};
        u_host.frame(n == 24 ? {f, crc8(f) ^ bad} : {8'h00, f}, n, rbw);
        settle();
    endtask : send
    // oldest note against each completed read
    always @(posedge CLK) begin
        if (AVS_READ && AVS_WAITREQUEST === 1'b0) begin
            if (notes.size() == 0) begin
                chk("read without note", 32'h1, 32'h0);
            end else begin
                nt = notes.pop_front();
                chk("readdata", AVS_READDATA & nt.m, nt.d & nt.m);
            end
        end
    end
    initial begin
        repeat (12) @(posedge CLK);
        NRST <= 1'b1;
        ad = {ADDR2_PIN, ADDR1_PIN, ADDR0_PIN};
        rd(DMD_OFS_CTRL, 32'h0, 32'hffffffff);
        rd(DMD_OFS_MASK, 32'h0, 32'h1f);
        rd(DMD_OFS_PINS, 32'h0, 32'h100);
        bus(1'b1, DMD_OFS_MASK, 32'h1);
        for (int k = 0; k < 4; k++) begin
            seed = next_rand(seed);
            {CLEAR_PIN, CLEAR_VALUE_SELECT_PIN} <= seed[15:14];
            last = {seed[11:8], 1'b0, seed[6:0]};
            send(ad, 1'b0, last, 16, 8'h00);
            chk("irq", IRQ, 1);
            chk("drive", 32'(DRIVE), 32'(dexp(last)));
            rd(DMD_OFS_CTRL, last, 32'hfff);
            rd(DMD_OFS_STATUS, 32'h1, 32'h1);
            settle();
            chk("irq cleared", IRQ, 0);
        end
        send(ad ^ 3'h5, 1'b0, ~last & 12'hf7f, 16, 8'h00);
        rd(DMD_OFS_CTRL, last, 32'hfff);
        send(ad, 1'b0, 12'h015, 15, 8'h00);
        chk("masked irq", IRQ, 0);
        rd(DMD_OFS_STATUS, 32'h10, 32'h13);
        send(ad, 1'b1, 12'h05a, 16, 8'h00);
        send(ad ^ 3'h5, 1'b0, 12'h000, 16, 8'h00);
        chk("readback", rbw[15:0], {4'h0, last});
        send(ad, 1'b0, 12'h1b3, 16, 8'h00);
        send(ad, 1'b0, 12'h1b3, 24, 8'h00);
        rd(DMD_OFS_CTRL, 32'h1b3, 32'hfff);
        chk("fault idle", FAULT_PULL_OE, 0);
        send(ad, 1'b0, 12'h0c6, 24, 8'h01);
        chk("crc fault", FAULT_PULL_OE, 1);
        rd(DMD_OFS_STATUS, 32'h3, 32'h3);
        rd(DMD_OFS_CTRL, 32'h1b3, 32'hfff);
        DEV_RESET_N_PIN <= 1'b0;
        settle();
        DEV_RESET_N_PIN <= 1'b1;
        settle();
        chk("fault after reset", FAULT_PULL_OE, 0);
        rd(DMD_OFS_CTRL, 32'h0, 32'hfff);
        bus(1'b1, DMD_OFS_MASK, 32'h0c);
        OVER_TEMP <= 1'b1;
        settle();
        chk("hot fault", FAULT_PULL_OE, 1);
        chk("hot irq", IRQ, 1);
        rd(DMD_OFS_STATUS, 32'h4, 32'h4);
        OVER_TEMP <= 1'b0;
        OPEN_CIRCUIT <= 1'b1;
        settle();
        chk("open fault", FAULT_PULL_OE, 1);
        chk("open alert sw", OPEN_ALERT_PULL_OE, 0);
        rd(DMD_OFS_STATUS, 32'h8, 32'h8);
        OPEN_CIRCUIT <= 1'b0;
        NRST <= 1'b0;
        // reset pin stays tied high in hardware mode
        MODE_STRAP_PIN <= 1'b1;
        repeat (12) @(posedge CLK);
        NRST <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            seed = next_rand(seed);
            u_host.hw_pins(seed[0], seed[1], seed[2]);
            {ADDR0_PIN, ADDR1_PIN, ADDR2_PIN} <= seed[5:3];
            {CLEAR_PIN, CLEAR_VALUE_SELECT_PIN} <= seed[7:6];
            {OVER_TEMP, OPEN_CIRCUIT} <= seed[9:8];
            settle();
            chk("hw drive", 32'(DRIVE), 32'({seed[5:2], seed[0],
                seed[1], seed[7], seed[6]}));
            chk("hw temp", FAULT_PULL_OE, seed[9]);
            chk("hw open", OPEN_ALERT_PULL_OE, seed[8]);
        end
        rd(DMD_OFS_CTRL, 32'h0, 32'hfff);
        rd(DMD_OFS_PINS, 32'h100, 32'h100);
        close_out();
    end
endmodule : dmd_front_tb
